/* File: hw/pmr_consts.svh */
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH
// Register indices inside the 32-entry management space.
`define PMR_REG_CTRL1      5'h16
`define PMR_REG_INT        5'h1B
`define PMR_REG_CTRL2      5'h1F
// Field positions.
`define PMR_BCAST_OFF_BIT  9
`define PMR_INT_POL_BIT    9
`define PMR_MDIX_DIS_BIT   13
`define PMR_MDIX_SEL_BIT   14
// Reset values.
`define PMR_CTRL1_RST      16'h0000
`define PMR_INT_EN_RST     8'h00
`define PMR_CTRL2_RST      16'h0000
// Cycles after reset release before the straps are taken.
`define PMR_STRAP_WAIT     2'h2
// Frame constants.
`define PMR_PREAMBLE_LEN   6'h20
`define PMR_HDR_LAST       4'hB
`define PMR_DATA_LAST      4'hF
`define PMR_OP_READ        2'h2
`define PMR_OP_WRITE       2'h1
// Strap codes for the back-to-back repeater modes.
`define PMR_CFG_B2B_MII    3'h6
`define PMR_CFG_B2B_RMII   3'h5
`endif

/* File: hw/pmr_pkg.sv */
package pmr_pkg;
    // Management frame walker states, one-hot.
    typedef enum logic [5:0] {
        PMR_PRE  = 6'h01,
        PMR_ST   = 6'h02,
        PMR_HDR  = 6'h04,
        PMR_TA1  = 6'h08,
        PMR_TA2  = 6'h10,
        PMR_DATA = 6'h20
    } pmr_state_t;
endpackage : pmr_pkg

/* File: hw/pmr_mgmt.sv */
// How it works
// - Read frame: preamble, start, op, address, turnaround, data.
// - Five-bit register address selects one of thirty-two.
// - Answer own address and broadcast zero.
// - Broadcast writes accepted; broadcast reads answered too.
// - Strap or control bit turns broadcast off.
// - Latch three-bit address strap after reset.
// - Enabled conditions alone assert the interrupt output.
// - Low byte records occurred interrupt conditions.
// - Reading interrupt register clears flags after data.
// - Control bit sets interrupt polarity, default low.
// - Auto pair selection on after reset; bit disables.
// - Manual mode: bit chooses straight or crossed pairs.
// - Auto mode follows detected partner pair usage.
// - Straight transmits first pair; crossed swaps roles.
// - Strap 110 selects four-bit back-to-back repeater.
// - Strap 101 selects two-bit back-to-back repeater.
// - Back-to-back: partner receive feeds our transmit.
`include "pmr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module pmr_mgmt
    import pmr_pkg::*;
(
    input  wire logic       sys_clk,                  // Core clock, 125 MHz.
    input  wire logic       reset_n,                  // Asynchronous reset, active low.
    input  wire logic       mdc,                      // Management clock pin from controller.
    input  wire logic       mdio_in,                  // Management data pin level.
    output logic            mdio_out,                 // Management data drive value.
    output logic            mdio_oe,                  // High while we drive the data pin.
    input  wire logic [2:0] phy_address_strap,        // Address strap pins.
    input  wire logic       broadcast_disable_strap,  // Broadcast-off strap pin.
    input  wire logic [2:0] config_strap,             // Mode strap pins.
    input  wire logic [7:0] int_event,                // Interrupt condition pulses from core.
    output logic            interrupt_output,         // Interrupt pin, polarity programmable.
    input  wire logic       partner_crossed,          // Core detector: partner uses crossed pairs.
    output logic            mdix_select,              // High selects crossed pair assignment.
    output logic            b2b_mii_mode,             // Four-bit repeater mode active.
    output logic            b2b_rmii_mode,            // Two-bit repeater mode active.
    input  wire logic       tx_en_pin,                // Transmit enable pin.
    input  wire logic [3:0] txd_pin,                  // Transmit data pins.
    output logic            core_tx_en,               // Transmit enable toward core.
    output logic [3:0]      core_txd                  // Transmit data toward core.
);
    // Pin synchronisers; the first stages feed only the second stages.
    logic [2:0] mdc_sync_ff;        // Stages two and three feed the edge detector.
    logic [1:0] mdio_sync_ff;       // Data pin, same delay as the clock stage two.
    logic [2:0] pad_s1_ff;          // Address strap first stage.
    logic [2:0] pad_s2_ff;          // Address strap second stage.
    logic [3:0] cfg_s1_ff;          // Mode and broadcast straps first stage.
    logic [3:0] cfg_s2_ff;          // Mode and broadcast straps second stage.
    logic [4:0] tx_s1_ff;           // Transmit pins first stage.
    logic [4:0] tx_s2_ff;           // Transmit pins second stage.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mdc_sync_ff  <= 3'h0;
            mdio_sync_ff <= 2'h3;
            pad_s1_ff    <= 3'h0;
            pad_s2_ff    <= 3'h0;
            cfg_s1_ff    <= 4'h0;
            cfg_s2_ff    <= 4'h0;
            tx_s1_ff     <= 5'h00;
            tx_s2_ff     <= 5'h00;
        end
        else
        begin
            mdc_sync_ff  <= {mdc_sync_ff[1:0], mdc};
            mdio_sync_ff <= {mdio_sync_ff[0], mdio_in};
            pad_s1_ff    <= phy_address_strap;
            pad_s2_ff    <= pad_s1_ff;
            cfg_s1_ff    <= {broadcast_disable_strap, config_strap};
            cfg_s2_ff    <= cfg_s1_ff;
            tx_s1_ff     <= {tx_en_pin, txd_pin};
            tx_s2_ff     <= tx_s1_ff;
        end
    end
    // A rising management clock edge, seen two cycles late like the data bit.
    wire mdc_rise = mdc_sync_ff[1] & ~mdc_sync_ff[2];
    wire mdio_bit = mdio_sync_ff[1];
    // Straps are caught by a clocked process once the synchronisers have filled.
    logic [1:0] strap_wait_ff;      // Cycles since reset release.
    logic       strap_taken_ff;     // Straps have been captured.
    logic [2:0] phy_addr_ff;        // Latched device address.
    logic [3:0] strap_cfg_ff;       // Latched broadcast-off and mode straps.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_wait_ff  <= 2'h0;
            strap_taken_ff <= 1'b0;
            phy_addr_ff    <= 3'h0;
            strap_cfg_ff   <= 4'h0;
        end
        else if (!strap_taken_ff)
        begin
            strap_wait_ff <= strap_wait_ff + 2'h1;
            if (strap_wait_ff == `PMR_STRAP_WAIT)   // Both sync stages hold fresh samples.
            begin
                strap_taken_ff <= 1'b1;
                phy_addr_ff    <= pad_s2_ff;
                strap_cfg_ff   <= cfg_s2_ff;
            end
        end
    end
    // Repeater modes come from the mode straps alone.
    assign b2b_mii_mode  = strap_taken_ff && (strap_cfg_ff[2:0] == `PMR_CFG_B2B_MII);
    assign b2b_rmii_mode = strap_taken_ff && (strap_cfg_ff[2:0] == `PMR_CFG_B2B_RMII);
    // Back-to-back: pins carry the partner's receive side; two-bit mode zeroes lanes 3:2.
    logic       core_tx_en_ff;      // Registered transmit enable.
    logic [3:0] core_txd_ff;        // Registered transmit data.
    wire  [3:0] tx_lane_mask = b2b_rmii_mode ? 4'h3 : 4'hF;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            core_tx_en_ff <= 1'b0;
            core_txd_ff   <= 4'h0;
        end
        else
        begin
            core_tx_en_ff <= tx_s2_ff[4];
            core_txd_ff   <= tx_s2_ff[3:0] & tx_lane_mask;
        end
    end
    assign core_tx_en = core_tx_en_ff;
    assign core_txd   = core_txd_ff;
    // Software-visible registers.
    logic [15:0] ctrl1_ff;          // Control 1, holds broadcast-off.
    logic [7:0]  int_en_ff;         // Interrupt enables.
    logic [7:0]  int_stat_ff;       // Sticky interrupt flags.
    logic [15:0] ctrl2_ff;          // Control 2, polarity and pair selection.
    // Read mux; registers the block does not hold read as zero.
    function automatic logic [15:0] rd_mux(input logic [4:0] a, input logic [15:0] c1,
                                           input logic [15:0] ie, input logic [15:0] c2);
        case (a)
            `PMR_REG_CTRL1: return c1;
            `PMR_REG_INT:   return ie;
            `PMR_REG_CTRL2: return c2;
            default:        return 16'h0000;
        endcase
    endfunction : rd_mux
    // Address match: own address, or zero while broadcast is on.
    wire       bcast_on = ~strap_cfg_ff[3] & ~ctrl1_ff[`PMR_BCAST_OFF_BIT];
    // Frame walker.
    pmr_state_t  state_ff;          // Current frame field.
    logic [5:0]  ones_ff;           // Preamble ones counted, saturating.
    logic [3:0]  cnt_ff;            // Bit index inside header or data.
    logic [15:0] shift_ff;          // Incoming bits, or outgoing read data.
    logic        is_read_ff;        // Matched read in progress.
    logic        is_write_ff;       // Matched write in progress.
    logic [4:0]  reg_ff;            // Register addressed by this frame.
    logic        mdio_out_ff;       // Drive value.
    logic        mdio_oe_ff;        // Drive enable.
    wire [11:0] hdr      = {shift_ff[10:0], mdio_bit};
    wire [1:0]  hdr_op   = hdr[11:10];
    wire [4:0]  hdr_phy  = hdr[9:5];
    wire [4:0]  hdr_reg  = hdr[4:0];
    wire        hdr_hit  = (hdr_phy[4:3] == 2'h0) && ((hdr_phy[2:0] == phy_addr_ff)
                           || ((hdr_phy == 5'h00) && bcast_on));
    wire        data_end = mdc_rise && (state_ff == PMR_DATA) && (cnt_ff == `PMR_DATA_LAST);
    wire        wr_commit = data_end && is_write_ff;
    wire [15:0] wr_data  = {shift_ff[14:0], mdio_bit};
    wire        int_rd_clear = data_end && is_read_ff && (reg_ff == `PMR_REG_INT);
    // The walker advances only on rising management clock edges.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff    <= PMR_PRE;
            ones_ff     <= 6'h00;
            cnt_ff      <= 4'h0;
            shift_ff    <= 16'h0000;
            is_read_ff  <= 1'b0;
            is_write_ff <= 1'b0;
            reg_ff      <= 5'h00;
            mdio_out_ff <= 1'b0;
            mdio_oe_ff  <= 1'b0;
        end
        else if (mdc_rise)
        begin
            case (state_ff)
                PMR_PRE:
                begin
                    // A zero after 32 ones is the first start bit.
                    if (mdio_bit)
                        ones_ff <= (ones_ff == `PMR_PREAMBLE_LEN) ? ones_ff : ones_ff + 6'h01;
                    else
                    begin
                        ones_ff <= 6'h00;
                        if (ones_ff == `PMR_PREAMBLE_LEN)
                            state_ff <= PMR_ST;
                    end
                end
                PMR_ST:
                begin
                    // The second start bit must be one, else hunt again.
                    cnt_ff   <= 4'h0;
                    state_ff <= mdio_bit ? PMR_HDR : PMR_PRE;
                end
                PMR_HDR:
                begin
                    shift_ff <= {shift_ff[14:0], mdio_bit};
                    cnt_ff   <= cnt_ff + 4'h1;
                    if (cnt_ff == `PMR_HDR_LAST)
                    begin
                        reg_ff      <= hdr_reg;
                        is_read_ff  <= hdr_hit && (hdr_op == `PMR_OP_READ);
                        is_write_ff <= hdr_hit && (hdr_op == `PMR_OP_WRITE);
                        // Snapshot read data now; flags set later are cleared at data end unless set in that cycle.
                        shift_ff    <= rd_mux(hdr_reg, ctrl1_ff, {int_en_ff, int_stat_ff},
                                              ctrl2_ff);
                        // Foreign or malformed frames are dropped without driving.
                        state_ff    <= (hdr_hit && (hdr_op == `PMR_OP_READ
                                        || hdr_op == `PMR_OP_WRITE)) ? PMR_TA1 : PMR_PRE;
                    end
                end
                PMR_TA1:
                begin
                    // First turnaround bit is released; we drive zero in the second.
                    state_ff    <= PMR_TA2;
                    mdio_out_ff <= 1'b0;
                    mdio_oe_ff  <= is_read_ff;
                end
                PMR_TA2:
                begin
                    state_ff    <= PMR_DATA;
                    cnt_ff      <= 4'h0;
                    mdio_out_ff <= shift_ff[15];
                    shift_ff    <= {shift_ff[14:0], 1'b0};  // A write refills all 16 bits.
                end
                PMR_DATA:
                begin
                    cnt_ff <= cnt_ff + 4'h1;
                    // Writes shift in controller data; reads shift out ours.
                    shift_ff    <= is_read_ff ? {shift_ff[14:0], 1'b0} : wr_data;
                    mdio_out_ff <= shift_ff[15];
                    if (cnt_ff == `PMR_DATA_LAST)
                    begin
                        state_ff    <= PMR_PRE;
                        mdio_oe_ff  <= 1'b0;
                        is_read_ff  <= 1'b0;
                        is_write_ff <= 1'b0;
                        ones_ff     <= 6'h00;
                    end
                end
                default:
                begin
                    state_ff   <= PMR_PRE;
                    mdio_oe_ff <= 1'b0;
                end
            endcase
        end
    end
    assign mdio_out = mdio_out_ff;
    assign mdio_oe  = mdio_oe_ff;
    // Register writes and sticky flags; a new event beats a read clear.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl1_ff    <= `PMR_CTRL1_RST;
            int_en_ff   <= `PMR_INT_EN_RST;
            int_stat_ff <= 8'h00;
            ctrl2_ff    <= `PMR_CTRL2_RST;
        end
        else
        begin
            if (wr_commit && (reg_ff == `PMR_REG_CTRL1))
                ctrl1_ff <= wr_data;
            if (wr_commit && (reg_ff == `PMR_REG_INT))
                int_en_ff <= wr_data[15:8];
            if (wr_commit && (reg_ff == `PMR_REG_CTRL2))
                ctrl2_ff <= wr_data;
            int_stat_ff <= (int_rd_clear ? 8'h00 : int_stat_ff) | int_event;
        end
    end
    // Interrupt pin, registered; polarity bit low means active low.
    logic intr_ff;                  // Pin level.
    wire  int_pending = |(int_en_ff & int_stat_ff);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            intr_ff <= 1'b1;
        else
            intr_ff <= ctrl2_ff[`PMR_INT_POL_BIT] ? int_pending : ~int_pending;
    end
    assign interrupt_output = intr_ff;
    // Pair selection; crossed assignment swaps transmit and receive pairs.
    logic mdix_ff;                  // Selected assignment.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            mdix_ff <= 1'b0;
        else if (ctrl2_ff[`PMR_MDIX_DIS_BIT])
            mdix_ff <= ctrl2_ff[`PMR_MDIX_SEL_BIT];
        else
            mdix_ff <= partner_crossed;
    end
    assign mdix_select = mdix_ff;
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_ta_drives_zero: assert property ($rose(mdio_oe_ff) |-> !mdio_out_ff)
        else $error("turnaround did not start with zero");
    a_quiet_unless_read: assert property (mdio_oe_ff |-> is_read_ff)
        else $error("data line driven outside a matched read");
    a_flags_clear: assert property (int_rd_clear && int_event == 8'h00 |=> int_stat_ff == 8'h00)
        else $error("flags not cleared after register read");
    a_flag_sticky: assert property (int_event != 8'h00 |=> (int_stat_ff & $past(int_event))
                                     == $past(int_event))
        else $error("interrupt event lost");
    a_intr_level: assert property (##1 (interrupt_output
        == ($past(ctrl2_ff[9]) ? $past(int_pending) : !$past(int_pending))))
        else $error("interrupt level wrong");
    a_mdix_manual: assert property (ctrl2_ff[13] |=> mdix_select == $past(ctrl2_ff[14]))
        else $error("manual pair choice not followed");
    a_mdix_auto: assert property (!ctrl2_ff[13] |=> mdix_select == $past(partner_crossed))
        else $error("auto pair choice not followed");
    a_strap_latch: assert property ($rose(strap_taken_ff) |-> phy_addr_ff == $past(pad_s2_ff))
        else $error("address strap not latched");
    a_b2b_mii: assert property ($rose(strap_taken_ff) |-> (b2b_mii_mode
        == ($past(cfg_s2_ff[2:0]) == 3'h6)) && (b2b_rmii_mode == ($past(cfg_s2_ff[2:0]) == 3'h5)))
        else $error("repeater mode not taken from the straps");
    a_bcast_off: assert property (mdc_rise && state_ff == PMR_HDR && cnt_ff == 4'hB
        && hdr_phy == 5'h00 && phy_addr_ff != 3'h0 && (strap_cfg_ff[3] || ctrl1_ff[9])
        |=> !is_read_ff && !is_write_ff) else $error("address zero still taken as broadcast");
    c_read_done:  cover property (data_end && is_read_ff);
    c_write_done: cover property (wr_commit);
    c_bcast_hit:  cover property (mdc_rise && state_ff == PMR_HDR && cnt_ff == 4'hB
                                  && hdr_hit && hdr_phy == 5'h00);
    c_intr_fire:  cover property (int_pending && !ctrl2_ff[9] && !interrupt_output);
endmodule : pmr_mgmt
`default_nettype wire

/* File: verification/pmr_mgmt_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module pmr_mgmt_ctrl
(
    input  wire logic sys_clk,   // Core clock that paces the link clock.
    input  wire logic mdio_wire, // Resolved level of the data wire.
    output logic      mdc,       // Link clock, still between frames.
    output logic      ctl_oe,    // High while the controller drives the wire.
    output logic      ctl_d      // Value driven by the controller.
);
    // Half of a 160 ns link period in core cycles, well under 10 MHz.
    localparam int HALF_CYC = 10;
    initial
    begin
        mdc    = 1'b0;
        ctl_oe = 1'b0;
        ctl_d  = 1'b0;
    end
    // Waits whole core cycles and lands just after the edge.
    task automatic gap(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : gap
    // One frame; each bit changes in the low phase, after the previous rise.
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [63:0] seen);
        logic [63:0] frm;
        frm = {32'hFFFF_FFFF, 2'b01, op, phy, rg, 2'b10, wd};
        for (int i = 0; i < 64; i++)
        begin
            // A read hands the wire over from the turnaround onward.
            ctl_oe = (op == 2'h1) || (i < 46);
            ctl_d  = frm[63 - i];
            gap(HALF_CYC);
            seen[63 - i] = mdio_wire;
            mdc = 1'b1;
            gap(HALF_CYC);
            mdc = 1'b0;
        end
        // Released wire idles high on its pull-up; the clock stands still.
        ctl_oe = 1'b0;
        gap(HALF_CYC);
    endtask : xfer
endmodule : pmr_mgmt_ctrl
`default_nettype wire

/* File: verification/tb.sv */
`include "pmr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       sys_clk, reset_n, mdc, mdio_wire, mdio_out, mdio_oe;
    logic       ctl_oe, ctl_d, bcast_off, interrupt_output, partner_crossed;
    logic       mdix_select, b2b_mii, b2b_rmii, tx_en_pin, core_tx_en, oe_seen;
    logic [2:0] phy_strap, cfg_strap;
    logic [7:0] int_event;
    logic [3:0] txd_pin, core_txd;
    int         err_total, total_checks;
    // Nobody driving leaves the wire on its pull-up.
    assign mdio_wire = mdio_oe ? mdio_out : (ctl_oe ? ctl_d : 1'b1);
    pmr_mgmt dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_wire),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_address_strap(phy_strap),
        .broadcast_disable_strap(bcast_off), .config_strap(cfg_strap),
        .int_event(int_event), .interrupt_output(interrupt_output),
        .partner_crossed(partner_crossed), .mdix_select(mdix_select),
        .b2b_mii_mode(b2b_mii), .b2b_rmii_mode(b2b_rmii), .tx_en_pin(tx_en_pin),
        .txd_pin(txd_pin), .core_tx_en(core_tx_en), .core_txd(core_txd));
    pmr_mgmt_ctrl ctl_u (.sys_clk(sys_clk), .mdio_wire(mdio_wire), .mdc(mdc),
        .ctl_oe(ctl_oe), .ctl_d(ctl_d));
    always #4 sys_clk = ~sys_clk;
    // Sticky note of any device drive, cleared before each read.
    always @(posedge sys_clk)
        if (mdio_oe === 1'b1)
            oe_seen <= 1'b1;
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // Straps are held across the release so the latch sees them settled.
    task automatic do_reset(input logic [2:0] ad, input logic bc, input logic [2:0] cf);
        reset_n   = 1'b0;
        phy_strap = ad;
        bcast_off = bc;
        cfg_strap = cf;
        step(20);
        reset_n = 1'b1;
        step(8);
    endtask : do_reset
    task automatic wr(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
        logic [63:0] s;
        ctl_u.xfer(`PMR_OP_WRITE, phy, rg, d, s);
    endtask : wr
    // A read that is answered shows 1 then 0 in turnaround; an ignored one stays high.
    task automatic rd(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp,
                      input logic ans);
        logic [63:0] s;
        oe_seen = 1'b0;
        ctl_u.xfer(`PMR_OP_READ, phy, rg, 16'h0000, s);
        chk("turnaround", {14'h0, ans ? 2'b10 : 2'b11}, {14'h0, s[17:16]});
        chk("read data", ans ? exp : 16'hFFFF, s[15:0]);
        chk("device drove", {15'h0, ans}, {15'h0, oe_seen});
    endtask : rd
    task automatic pulse(input logic [7:0] e);
        int_event = e;
        step(1);
        int_event = 8'h00;
        step(3);
    endtask : pulse
    // Bounded run: a hang counts as a mismatch and closes the run.
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
    initial
    begin
        sys_clk = 1'b0;
        err_total = 0;
        total_checks = 0;
        oe_seen = 1'b0;
        int_event = 8'h00;
        partner_crossed = 1'b1;
        tx_en_pin = 1'b1;
        txd_pin = 4'hA;
        do_reset(3'h5, 1'b0, `PMR_CFG_B2B_MII);
        chk("int idle", 16'h1, {15'h0, interrupt_output});
        chk("mii mode", 16'h2, {14'h0, b2b_mii, b2b_rmii});
        chk("auto cross", 16'h1, {15'h0, mdix_select});
        chk("b2b tx", 16'h1A, {11'h0, core_tx_en, core_txd});
        partner_crossed = 1'b0;
        step(3);
        chk("auto straight", 16'h0, {15'h0, mdix_select});
        wr(5'h05, `PMR_REG_CTRL2, 16'h6000);
        chk("manual cross", 16'h1, {15'h0, mdix_select});
        rd(5'h05, `PMR_REG_CTRL2, 16'h6000, 1'b1);
        rd(5'h05, 5'h02, 16'h0000, 1'b1);
        rd(5'h03, `PMR_REG_CTRL2, 16'h0000, 1'b0);
        rd(5'h0D, `PMR_REG_CTRL2, 16'h0000, 1'b0);
        wr(5'h00, `PMR_REG_CTRL2, 16'h0200);
        chk("polarity high", 16'h0, {15'h0, interrupt_output});
        chk("auto again", 16'h0, {15'h0, mdix_select});
        rd(5'h00, `PMR_REG_CTRL2, 16'h0200, 1'b1);
        wr(5'h05, `PMR_REG_INT, 16'h0300);
        pulse(8'h04);
        chk("masked event", 16'h0, {15'h0, interrupt_output});
        pulse(8'h01);
        chk("enabled event", 16'h1, {15'h0, interrupt_output});
        rd(5'h05, `PMR_REG_INT, 16'h0305, 1'b1);
        chk("int cleared", 16'h0, {15'h0, interrupt_output});
        rd(5'h05, `PMR_REG_INT, 16'h0300, 1'b1);
        wr(5'h05, `PMR_REG_CTRL1, 16'h0200);
        rd(5'h00, `PMR_REG_INT, 16'h0000, 1'b0);
        // Strap-off broadcast with a new address and the two-bit repeater.
        txd_pin = 4'hF;
        do_reset(3'h2, 1'b1, `PMR_CFG_B2B_RMII);
        chk("rmii mode", 16'h1, {14'h0, b2b_mii, b2b_rmii});
        chk("dibit tx", 16'h13, {11'h0, core_tx_en, core_txd});
        chk("int default", 16'h1, {15'h0, interrupt_output});
        rd(5'h00, `PMR_REG_CTRL2, 16'h0000, 1'b0);
        rd(5'h02, `PMR_REG_INT, 16'h0000, 1'b1);
        rd(5'h05, `PMR_REG_INT, 16'h0000, 1'b0);
        wr(5'h02, `PMR_REG_INT, 16'h0100);
        pulse(8'h01);
        chk("int active low", 16'h0, {15'h0, interrupt_output});
        rd(5'h02, `PMR_REG_INT, 16'h0101, 1'b1);
        chk("low int cleared", 16'h1, {15'h0, interrupt_output});
        complete_run();
    end
endmodule : tb
`default_nettype wire
